/* File: hw/ptm_pkg.sv */
// Package of register map, field layout and reset values for the paired timer
package ptm_pkg;

  localparam int unsigned DataWidth = 32;
  localparam int unsigned AddrWidth = 8;

  // Register byte offsets, one aligned word each
  localparam logic [7:0] EvenControlAddr = 8'h00;
  localparam logic [7:0] OddControlAddr  = 8'h04;
  localparam logic [7:0] PeriodLowAddr   = 8'h08;
  localparam logic [7:0] PeriodHighAddr  = 8'h0C;
  localparam logic [7:0] CountLowAddr    = 8'h10;
  localparam logic [7:0] CountHighAddr   = 8'h14;
  localparam logic [7:0] StatusAddr      = 8'h18;
  localparam logic [7:0] IrqControlAddr  = 8'h1C;

  // Control register fields
  localparam int unsigned TimerOnBit      = 15;
  localparam int unsigned GatedAccBit     = 6;
  localparam int unsigned PrescaleLsb     = 4;
  localparam int unsigned PrescaleWidth   = 2;
  localparam int unsigned Pair32Bit       = 3;
  localparam int unsigned ClockSourceBit  = 1;
  localparam logic [15:0] ControlMask     = 16'h807A;

  // Status register fields: bit0 even flag, bit1 odd flag
  localparam int unsigned EvenFlagBit     = 0;
  localparam int unsigned OddFlagBit      = 1;

  // Interrupt control fields: enables and priorities
  localparam int unsigned EvenIeBit       = 0;
  localparam int unsigned OddIeBit        = 1;
  localparam int unsigned EvenIpLsb       = 4;
  localparam int unsigned OddIpLsb        = 8;
  localparam int unsigned PriorityWidth   = 3;

  localparam logic [15:0] ControlReset    = 16'h0000;
  localparam logic [15:0] PeriodReset     = 16'hFFFF;
  localparam logic [15:0] CountReset      = 16'h0000;

  // Prescale ratios 1, 8, 64, 256 as terminal counts
  localparam logic [7:0] PrescaleDiv1     = 8'h00;
  localparam logic [7:0] PrescaleDiv8     = 8'h07;
  localparam logic [7:0] PrescaleDiv64    = 8'h3F;
  localparam logic [7:0] PrescaleDiv256   = 8'hFF;

  typedef enum logic [1:0] {
    PTM_MODE_TIMER16 = 2'b00,
    PTM_MODE_TIMER32 = 2'b01,
    PTM_MODE_COUNT32 = 2'b10,
    PTM_MODE_COUNT16 = 2'b11
  } ptm_mode_type;

endpackage : ptm_pkg

/* File: hw/ptm_tick_gen.sv */
// Prescaler and input qualifier producing count ticks for one timer
`timescale 1ns/10ps
`default_nettype none

module ptm_tick_gen (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       enable,
  input  wire logic       clockSource,
  input  wire logic       gatedAccumulate,
  input  wire logic [1:0] prescaleSelect,
  input  wire logic       extClock,
  input  wire logic       gateIn,
  output logic            tick
);

  logic [7:0] divCount;
  logic [7:0] divLimit;
  logic       extClockLast;
  logic       rawEvent;
  logic       gateOk;

  always_comb begin
    case (prescaleSelect)
      2'd0:    divLimit = ptm_pkg::PrescaleDiv1;
      2'd1:    divLimit = ptm_pkg::PrescaleDiv8;
      2'd2:    divLimit = ptm_pkg::PrescaleDiv64;
      default: divLimit = ptm_pkg::PrescaleDiv256;
    endcase
  end

  // Rising edge of sampled external clock counts; gate only in timer mode
  assign rawEvent = clockSource ? (extClock & ~extClockLast) : 1'b1;
  assign gateOk   = gatedAccumulate & ~clockSource ? gateIn : 1'b1;

  always_ff @(posedge clk) begin
    if (rst) begin
      extClockLast <= 1'b0;
    end else begin
      extClockLast <= extClock;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !enable) begin
      divCount <= 8'h00;
    end else if (rawEvent && gateOk) begin
      divCount <= (divCount >= divLimit) ? 8'h00 : divCount + 8'h01;
    end
  end

  assign tick = enable && rawEvent && gateOk && (divCount >= divLimit);

endmodule : ptm_tick_gen

`default_nettype wire

/* File: hw/ptm_counter16.sv */
// One 16-bit count stage with load and clear; the period compare is done in the top
`timescale 1ns/10ps
`default_nettype none

module ptm_counter16 #(
  parameter int unsigned Width = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             advance,
  input  wire logic             clear,
  input  wire logic             load,
  input  wire logic [Width-1:0] loadValue,
  output logic      [Width-1:0] count
);

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= '0;
    end else if (load) begin
      count <= loadValue;
    end else if (advance) begin
      count <= clear ? '0 : count + 1'b1;
    end
  end

endmodule : ptm_counter16

`default_nettype wire

/* File: hw/paired_timer_32bit.sv */
// Top of a timer pair: APB registers, 16/32-bit mode steering and flags
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Pair runs as two 16-bit timers, one 32-bit timer or 32-bit counter
// - Independent 16-bit timers support all 16-bit modes except asynchronous counting
// - Timers keep running in idle and sleep; no low-power stop input
// - In 32-bit mode a 32-bit count to period match raises the interrupt
// - Only this first pair's timers drive the capture/compare time base
// - Only the first pair in 32-bit mode produces the ADC trigger
// - Each 16-bit timer works as synchronous timer or synchronous counter
// - In 32-bit mode even timer holds low word, odd holds high word
// - In 32-bit mode odd control bits are ignored; even control rules
// - In 32-bit mode clock and gate come from the even inputs
// - 32-bit interrupt uses odd flag, odd enable and odd 3-bit priority
// - In 32-bit mode prescale comes from even prescale_select
// - 32-bit period is period_high above period_low
// - Running 32-bit count reads as count_high above count_low
module paired_timer_32bit #(
  parameter bit FirstPair = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        evenClockIn,
  input  wire logic        evenGateIn,
  input  wire logic        oddClockIn,
  input  wire logic        oddGateIn,
  output logic             evenIrq,
  output logic             oddIrq,
  output logic [2:0]       evenIrqPriority,
  output logic [2:0]       oddIrqPriority,
  output logic             evenTimeBase,
  output logic             oddTimeBase,
  output logic             adcTrigger
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [15:0] evenControl;
  logic [15:0] oddControl;
  logic [15:0] periodLow;
  logic [15:0] periodHigh;
  logic [1:0]  flags;
  logic [15:0] irqControl;
  logic [15:0] countLow;
  logic [15:0] countHigh;

  logic        wrEn;
  logic        rdEn;
  logic        addrOk;

  assign pready  = 1'b1;
  assign addrOk  = (paddr[1:0] == 2'b00) && (paddr <= ptm_pkg::IrqControlAddr);
  assign pslverr = psel && penable && !addrOk;
  assign wrEn    = psel && penable && pwrite && addrOk;
  assign rdEn    = psel && !penable && !pwrite;

  always_ff @(posedge clk) begin
    if (rst) begin
      evenControl <= ptm_pkg::ControlReset;
      oddControl  <= ptm_pkg::ControlReset;
      periodLow   <= ptm_pkg::PeriodReset;
      periodHigh  <= ptm_pkg::PeriodReset;
      irqControl  <= 16'h0000;
    end else if (wrEn) begin
      case (paddr)
        ptm_pkg::EvenControlAddr: evenControl <= pwdata[15:0] & ptm_pkg::ControlMask;
        ptm_pkg::OddControlAddr:  oddControl  <= pwdata[15:0] & ptm_pkg::ControlMask;
        ptm_pkg::PeriodLowAddr:   periodLow   <= pwdata[15:0];
        ptm_pkg::PeriodHighAddr:  periodHigh  <= pwdata[15:0];
        ptm_pkg::IrqControlAddr:  irqControl  <= pwdata[15:0] & 16'h0773;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode steering

  logic       pair32;
  logic       evenOn;
  logic       oddOn;
  logic       oddCs;
  logic       oddGate;
  logic [1:0] oddPs;
  logic       oddClk;
  logic       oddGateSel;
  ptm_pkg::ptm_mode_type mode;

  assign pair32     = evenControl[ptm_pkg::Pair32Bit];
  assign evenOn     = evenControl[ptm_pkg::TimerOnBit];
  assign mode       = pair32 ? (evenControl[ptm_pkg::ClockSourceBit] ? ptm_pkg::PTM_MODE_COUNT32
                                                                     : ptm_pkg::PTM_MODE_TIMER32)
                             : ptm_pkg::PTM_MODE_TIMER16;
  // Odd control ignored in 32-bit mode
  assign oddOn      = pair32 ? 1'b0 : oddControl[ptm_pkg::TimerOnBit];
  assign oddCs      = oddControl[ptm_pkg::ClockSourceBit];
  assign oddGate    = oddControl[ptm_pkg::GatedAccBit];
  assign oddPs      = oddControl[ptm_pkg::PrescaleLsb +: ptm_pkg::PrescaleWidth];
  assign oddClk     = oddClockIn;
  assign oddGateSel = oddGateIn;

  ////////////////////////////////////////////////////////////////////////////
  // Tick generation; no sleep input, so counting never stops for low power

  logic evenTick;
  logic oddTick;

  ptm_tick_gen u_even_tick (
    .clk             (clk),
    .rst             (rst),
    .enable          (evenOn),
    .clockSource     (evenControl[ptm_pkg::ClockSourceBit]),
    .gatedAccumulate (evenControl[ptm_pkg::GatedAccBit]),
    .prescaleSelect  (evenControl[ptm_pkg::PrescaleLsb +: ptm_pkg::PrescaleWidth]),
    .extClock        (evenClockIn),
    .gateIn          (evenGateIn),
    .tick            (evenTick)
  );

  // Synchronous sampling only: no asynchronous counter path
  ptm_tick_gen u_odd_tick (
    .clk             (clk),
    .rst             (rst),
    .enable          (oddOn),
    .clockSource     (oddCs),
    .gatedAccumulate (oddGate),
    .prescaleSelect  (oddPs),
    .extClock        (oddClk),
    .gateIn          (oddGateSel),
    .tick            (oddTick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counters and match

  logic        evenMatch16;
  logic        oddMatch16;
  logic        match32;
  logic        evenAdvance;
  logic        evenClear;
  logic        oddAdvance;
  logic        oddClear;
  logic        loadLow;
  logic        loadHigh;

  assign evenMatch16 = (countLow == periodLow);
  assign oddMatch16  = (countHigh == periodHigh);
  assign match32     = {countHigh, countLow} == {periodHigh, periodLow};

  assign evenAdvance = evenTick;
  assign evenClear   = pair32 ? match32 : evenMatch16;
  // High word carries on low-word rollover in 32-bit mode
  assign oddAdvance  = pair32 ? (evenTick && (match32 || countLow == 16'hFFFF)) : oddTick;
  assign oddClear    = pair32 ? match32 : oddMatch16;

  assign loadLow  = wrEn && (paddr == ptm_pkg::CountLowAddr);
  assign loadHigh = wrEn && (paddr == ptm_pkg::CountHighAddr);

  ptm_counter16 #(
    .Width (16)
  ) u_low (
    .clk       (clk),
    .rst       (rst),
    .advance   (evenAdvance),
    .clear     (evenClear),
    .load      (loadLow),
    .loadValue (pwdata[15:0]),
    .count     (countLow)
  );

  ptm_counter16 #(
    .Width (16)
  ) u_high (
    .clk       (clk),
    .rst       (rst),
    .advance   (oddAdvance),
    .clear     (oddClear),
    .load      (loadHigh),
    .loadValue (pwdata[15:0]),
    .count     (countHigh)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Flags: set wins over software clear (write one to clear)

  logic evenEvent;
  logic oddEvent;
  logic [1:0] clrMask;

  assign evenEvent = !pair32 && evenTick && evenMatch16;
  assign oddEvent  = pair32 ? (evenTick && match32) : (oddTick && oddMatch16);
  assign clrMask   = (wrEn && paddr == ptm_pkg::StatusAddr) ? pwdata[1:0] : 2'b00;

  always_ff @(posedge clk) begin
    if (rst) begin
      flags <= 2'b00;
    end else begin
      flags[ptm_pkg::EvenFlagBit] <= evenEvent || (flags[ptm_pkg::EvenFlagBit] && !clrMask[0]);
      flags[ptm_pkg::OddFlagBit]  <= oddEvent  || (flags[ptm_pkg::OddFlagBit]  && !clrMask[1]);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      evenIrq         <= 1'b0;
      oddIrq          <= 1'b0;
      evenIrqPriority <= 3'd0;
      oddIrqPriority  <= 3'd0;
      evenTimeBase    <= 1'b0;
      oddTimeBase     <= 1'b0;
      adcTrigger      <= 1'b0;
    end else begin
      evenIrq         <= flags[ptm_pkg::EvenFlagBit] && irqControl[ptm_pkg::EvenIeBit];
      oddIrq          <= flags[ptm_pkg::OddFlagBit] && irqControl[ptm_pkg::OddIeBit];
      evenIrqPriority <= irqControl[ptm_pkg::EvenIpLsb +: ptm_pkg::PriorityWidth];
      oddIrqPriority  <= irqControl[ptm_pkg::OddIpLsb +: ptm_pkg::PriorityWidth];
      evenTimeBase    <= FirstPair && (pair32 ? oddEvent : evenEvent);
      oddTimeBase     <= FirstPair && oddEvent;
      adcTrigger      <= FirstPair && pair32 && oddEvent;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered in setup cycle

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (rdEn) begin
      case (paddr)
        ptm_pkg::EvenControlAddr: prdata <= {16'h0000, evenControl};
        ptm_pkg::OddControlAddr:  prdata <= {16'h0000, oddControl};
        ptm_pkg::PeriodLowAddr:   prdata <= {16'h0000, periodLow};
        ptm_pkg::PeriodHighAddr:  prdata <= {16'h0000, periodHigh};
        ptm_pkg::CountLowAddr:    prdata <= {16'h0000, countLow};
        ptm_pkg::CountHighAddr:   prdata <= {16'h0000, countHigh};
        ptm_pkg::StatusAddr:      prdata <= {28'h000_0000, mode, flags};
        ptm_pkg::IrqControlAddr:  prdata <= {16'h0000, irqControl};
        default:                  prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : paired_timer_32bit

`default_nettype wire

/* File: bench/ptm_assertions.sv */
// Port checker for the paired timer, bound to its top
`timescale 1ns/10ps
`default_nettype none
module ptm_assertions (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        evenIrq,
  input wire logic        oddIrq,
  input wire logic [2:0]  evenIrqPriority,
  input wire logic [2:0]  oddIrqPriority,
  input wire logic        evenTimeBase,
  input wire logic        adcTrigger
);
  logic        acc;
  logic        unm;
  logic        wrOk;
  logic        mode32;
  logic        evenIe;
  logic        oddIe;
  logic [2:0]  evenPr;
  logic [2:0]  oddPr;
  logic [15:0] perLo;
  assign acc = psel && penable;
  assign unm = (paddr > 8'h1C) || (paddr[1:0] != 2'h0);
  assign wrOk = acc && pwrite && !unm;
  ////////////////////////////////////////////////////////////
  // Shadow of what software last wrote
  always_ff @(posedge clk) begin
    if (rst) begin
      mode32 <= 1'h0;
      evenIe <= 1'h0;
      oddIe <= 1'h0;
      evenPr <= 3'h0;
      oddPr <= 3'h0;
      perLo <= 16'hFFFF;
    end else if (wrOk) begin
      if (paddr == ptm_pkg::EvenControlAddr) mode32 <= pwdata[ptm_pkg::Pair32Bit];
      if (paddr == ptm_pkg::PeriodLowAddr) perLo <= pwdata[15:0];
      if (paddr == ptm_pkg::IrqControlAddr) begin
        evenIe <= pwdata[0];
        oddIe <= pwdata[1];
        evenPr <= pwdata[6:4];
        oddPr <= pwdata[10:8];
      end
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_err_unmapped: assert property (acc && unm |-> pslverr)
    else $error("no error on unmapped access");
  chk_err_mapped: assert property (acc && !unm |-> !pslverr)
    else $error("error on mapped access");
  chk_read_unmapped: assert property (acc && !pwrite && unm |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_period_readback: assert property (
    acc && !pwrite && paddr == ptm_pkg::PeriodLowAddr |-> prdata[15:0] == perLo)
    else $error("period readback wrong");
  chk_adc_pair_mode: assert property (adcTrigger |-> $past(mode32))
    else $error("trigger outside pair mode");
  chk_odd_irq_mask: assert property (oddIrq |-> $past(oddIe))
    else $error("odd irq while masked");
  chk_even_irq_mask: assert property (evenIrq |-> $past(evenIe))
    else $error("even irq while masked");
  chk_prio_copy: assert property (
    wrOk && paddr == ptm_pkg::IrqControlAddr |-> ##2 oddIrqPriority == oddPr && evenIrqPriority == evenPr)
    else $error("priority outputs wrong");
  cover property (adcTrigger);
  cover property (oddIrq);
  cover property (acc && pslverr);
  cover property (evenTimeBase);
endmodule : ptm_assertions

bind paired_timer_32bit ptm_assertions u_chk (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .evenIrq, .oddIrq, .evenIrqPriority, .oddIrqPriority, .evenTimeBase, .adcTrigger);
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the paired timer
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv;
  logic        evenClockIn, evenGateIn, oddClockIn, oddGateIn;
  logic        evenIrq, oddIrq, evenTimeBase, oddTimeBase, adcTrigger;
  logic [2:0]  evenIrqPriority, oddIrqPriority;
  int          fails, n_checks, t, ps, p, n, c, k;
  paired_timer_32bit u_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .evenClockIn, .evenGateIn, .oddClockIn, .oddGateIn, .evenIrq, .oddIrq, .evenIrqPriority, .oddIrqPriority,
    .evenTimeBase, .oddTimeBase, .adcTrigger);
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic timeout;
    fails++;
    summarize();
  endtask : timeout
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (pready === 1'h1) break;
    end
    if (i == 16) timeout();
    rv = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bus(1'h0, a, 32'h0000_0000);
  endtask : rd
  task automatic waitSig(input int s, input int lim);
    for (c = 0; c < lim; c++) begin
      @(posedge clk);
      #1;
      if ((s == 0 ? evenTimeBase : s == 1 ? oddTimeBase : adcTrigger) === 1'h1) break;
    end
    if (c == lim) timeout();
  endtask : waitSig
  function automatic int dv(input int s);
    return (s == 3) ? 256 : (1 << (3 * s));
  endfunction : dv
  ////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {evenClockIn, evenGateIn, oddClockIn, oddGateIn} = 4'h0;
    rst = 1'h1;
    fails = 0;
    n_checks = 0;
    k = $urandom(61191);
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    for (k = 0; k < 9; k++) begin
      rd(8'(4 * k));
      check(rv, (k == 2 || k == 3) ? 32'h0000_FFFF : 32'h0000_0000, "reset or unmapped value");
      check(32'(err), 32'(k == 8), "slave error");
    end
    for (t = 0; t < 2; t++) begin
      wr(8'h1C, 32'h0000_0001);
      for (ps = 0; ps < 4; ps++) begin
        p = $urandom_range(12, 3);
        wr(8'(4 * t), 32'h0000_0000);
        wr(8'(16 + 4 * t), 32'h0000_0000);
        wr(8'(8 + 4 * t), 32'(p));
        wr(8'(4 * t), 32'h0000_8000 | 32'(ps << 4));
        waitSig(t, 6000);
        waitSig(t, 6000);
        check(32'(c + 1), 32'((p + 1) * dv(ps)), "period interval");
      end
      wr(8'(4 * t), 32'h0000_0000);
      rd(8'h18);
      check(32'(rv[t]), 32'h0000_0001, "flag set");
      check(32'(t == 0 ? evenIrq : oddIrq), 32'(t == 0), "irq enable and mask");
      wr(8'h18, 32'(1 << t));
      rd(8'h18);
      check(32'(rv[t]), 32'h0000_0000, "flag cleared");
      check(32'(evenIrq), 32'h0000_0000, "irq dropped");
    end
    wr(8'h10, 32'h0000_0000);
    wr(8'h08, 32'h0000_FFFF);
    wr(8'h00, 32'h0000_8040);
    repeat (5) @(posedge clk);
    evenGateIn <= 1'h1;
    repeat (10) @(posedge clk);
    evenGateIn <= 1'h0;
    repeat (3) @(posedge clk);
    rd(8'h10);
    check(rv, 32'h0000_000A, "gated count");
    wr(8'h00, 32'h0000_8000);
    repeat (4) @(posedge clk);
    wr(8'h00, 32'h0000_0000);
    rd(8'h10);
    n = int'(rv);
    repeat (20) @(posedge clk);
    rd(8'h10);
    check(rv, 32'(n), "held count");
    n = $urandom_range(9, 3);
    wr(8'h10, 32'h0000_0000);
    wr(8'h00, 32'h0000_8002);
    repeat (n) begin
      evenClockIn <= 1'h1;
      repeat (2) @(posedge clk);
      evenClockIn <= 1'h0;
      repeat (2) @(posedge clk);
    end
    repeat (4) @(posedge clk);
    rd(8'h10);
    check(rv, 32'(n), "external edges");
    p = $urandom_range(7, 0);
    wr(8'h1C, 32'h0000_0002 | 32'(p << 8));
    // Priority outputs are registered one cycle after the register
    repeat (2) @(posedge clk);
    check(32'(oddIrqPriority), 32'(p), "odd priority");
    for (k = 0; k < 2; k++) begin
      wr(8'h00, 32'h0000_0048);
      wr(8'h04, 32'h0000_8030);
      wr(8'h10, 32'h0000_FFF0);
      wr(8'h14, 32'h0000_0000);
      wr(8'h08, 32'h0000_0005);
      wr(8'h0C, 32'(k + 1));
      evenGateIn <= 1'h1;
      oddGateIn <= 1'h0;
      wr(8'h00, 32'h0000_8048);
      if (k == 0) begin
        waitSig(2, 80);
        repeat (2) @(posedge clk);
        check(32'(oddIrq), 32'h0000_0001, "pair match irq");
      end else repeat (30) @(posedge clk);
      wr(8'h00, 32'h0000_0048);
      rd(8'h14);
      check(rv, 32'(k), "high word");
      rd(8'h10);
      check(32'(rv < 32'h0000_0040), 32'h0000_0001, "low word");
    end
    // Pair as 32-bit synchronous counter on even external edges
    wr(8'h10, 32'h0000_FFFE);
    wr(8'h14, 32'h0000_0000);
    wr(8'h00, 32'h0000_000A);
    wr(8'h00, 32'h0000_800A);
    repeat (3) begin
      evenClockIn <= 1'h1;
      repeat (2) @(posedge clk);
      evenClockIn <= 1'h0;
      repeat (2) @(posedge clk);
    end
    rd(8'h18);
    check(32'(rv[3:2]), 32'(ptm_pkg::PTM_MODE_COUNT32), "counter mode");
    rd(8'h14);
    check(rv, 32'h0000_0001, "counter carry");
    rd(8'h10);
    check(rv, 32'h0000_0001, "counter low word");
    summarize();
  end
endmodule : testbench
`default_nettype wire
